/* hw/dtsir_defs.svh */
// Offsets, field positions, reset values for the test, sleep and identifier register slice
`ifndef DTSIR_DEFS_SVH
`define DTSIR_DEFS_SVH

`define DTSIR_OFS_WORD0      8'h0C
`define DTSIR_OFS_WORD1      8'h0D
`define DTSIR_OFS_WORD5      8'h11
`define DTSIR_OFS_WORD6      8'h12
`define DTSIR_OFS_WORD7      8'h13
`define DTSIR_OFS_OVERRIDE   8'h14
`define DTSIR_OFS_SLEEP_MASK 8'h15
`define DTSIR_OFS_ID_LOW     8'h16
`define DTSIR_OFS_ID_LMID    8'h17
`define DTSIR_OFS_ID_UMID    8'h18
`define DTSIR_OFS_ID_HIGH    8'h19
`define DTSIR_OFS_CHK_CTRL   8'h1B
`define DTSIR_OFS_CHK_STAT   8'h1C

`define DTSIR_RST_WORD0      14'h0000
`define DTSIR_RST_WORD1      14'h36B6
`define DTSIR_RST_WORD2      14'h2AEA
`define DTSIR_RST_WORD3      14'h0545
`define DTSIR_RST_WORD4      14'h0585
`define DTSIR_RST_WORD5      14'h0949
`define DTSIR_RST_WORD6      14'h1515
`define DTSIR_RST_WORD7      14'h3ABA
`define DTSIR_RST_OVR_CODE   14'h0000
`define DTSIR_RST_SLEEP_MASK 16'hFFFF

`define DTSIR_POS_OVR_EN     15
`define DTSIR_POS_SLEEP_LO   8
`define DTSIR_POS_CHK_EN     0
`define DTSIR_POS_ERR_A      0
`define DTSIR_POS_ERR_B      1

`endif

/* hw/dtsir_pkg.sv */
// Types shared by the test, sleep and identifier register slice
package dtsir_pkg;
    typedef logic [7:0]  dtsir_addr_t;
    typedef logic [15:0] dtsir_word_t;
    typedef logic [13:0] dtsir_code_t;
    typedef logic [63:0] dtsir_id_t;
    typedef logic [7:0]  dtsir_sleep_t;
    typedef enum logic [0:0] {
        DTSIR_CHK_IDLE = 1'b0,
        DTSIR_CHK_RUN  = 1'b1
    } dtsir_chk_state_t;
endpackage

/* hw/dtsir_regs.sv */
// Test pattern, static override, sleep routing and die identifier registers
//
// Notes on behaviour
// - Word six: 14-bit writable, resets 0x1515
// - Word seven: 14-bit writable, resets 0x3ABA
// - Eight words form the input check reference
// - Override enable bit 15 forces static code
// - Static code 14 bits, reset zero, both converters
// - Sleep mask 16 bits, resets all ones
// - Mask one forwards sleep; zero keeps awake
// - Bits 15..12: conv A, B, fuse, temp
// - Bits 11..8: clock, data, sync, align
// - Identifier bits 15:0 at 0x16, read only
// - Identifier bits 31:16 at 0x17, read only
// - Further identifier slice at 0x18, read only
// - Reserved pattern and override bits read zero
// - Words one to five at 0x0D..0x11
// - 0x18 holds bits 47:32, 0x19 bits 63:48
`timescale 1ns/1ps
`default_nettype none
`include "dtsir_defs.svh"
module dtsir_regs #(
    parameter int WORDS = 8
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire dtsir_pkg::dtsir_addr_t  reg_addr,
    input  wire dtsir_pkg::dtsir_word_t  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output dtsir_pkg::dtsir_word_t       reg_rdata,
    // Input data path
    input  wire dtsir_pkg::dtsir_code_t  din_a,
    input  wire dtsir_pkg::dtsir_code_t  din_b,
    input  wire logic                    din_valid,
    // Converter codes
    output dtsir_pkg::dtsir_code_t       dac_a_code,
    output dtsir_pkg::dtsir_code_t       dac_b_code,
    // Sleep
    input  wire logic                    sleep_pin,
    output dtsir_pkg::dtsir_sleep_t      block_sleep,
    // Die identifier
    input  wire dtsir_pkg::dtsir_id_t    die_identifier_word,
    // Checker status
    output logic                         io_check_error
);
    import dtsir_pkg::*;

    // Pattern store, index 0 is word zero
    dtsir_code_t      pat_r [WORDS];
    logic             ovr_en_r;
    dtsir_code_t      ovr_code_r;
    dtsir_word_t      mask_r;
    logic             chk_en_r;
    logic             err_a_r;
    logic             err_b_r;
    dtsir_chk_state_t chk_state_r;
    dtsir_chk_state_t chk_state_nxt;
    logic [2:0]       chk_idx_r;
    logic             sleep_sync;

    // Address decode
    wire logic        pat_hit   = (reg_addr >= `DTSIR_OFS_WORD0) &&
                                  (reg_addr <= `DTSIR_OFS_WORD7);
    wire logic [2:0]  pat_idx   = 3'(reg_addr - `DTSIR_OFS_WORD0);
    wire logic        hit_ovr   = (reg_addr == `DTSIR_OFS_OVERRIDE);
    wire logic        hit_mask  = (reg_addr == `DTSIR_OFS_SLEEP_MASK);
    wire logic        hit_id0   = (reg_addr == `DTSIR_OFS_ID_LOW);
    wire logic        hit_id1   = (reg_addr == `DTSIR_OFS_ID_LMID);
    wire logic        hit_id2   = (reg_addr == `DTSIR_OFS_ID_UMID);
    wire logic        hit_id3   = (reg_addr == `DTSIR_OFS_ID_HIGH);
    wire logic        hit_ctrl  = (reg_addr == `DTSIR_OFS_CHK_CTRL);
    wire logic        hit_stat  = (reg_addr == `DTSIR_OFS_CHK_STAT);
    wire logic        wr_pat    = reg_wr && pat_hit;
    wire logic        wr_ovr    = reg_wr && hit_ovr;
    wire logic        wr_mask   = reg_wr && hit_mask;
    wire logic        wr_ctrl   = reg_wr && hit_ctrl;
    wire logic        wr_stat   = reg_wr && hit_stat;

    // Read selection; identifier slices have no write path at all
    wire dtsir_word_t rd_pat    = {2'b00, pat_r[pat_idx]};
    wire dtsir_word_t rd_ovr    = {ovr_en_r, 1'b0, ovr_code_r};
    wire dtsir_word_t rd_ctrl   = {15'h0000, chk_en_r};
    wire dtsir_word_t rd_stat   = {13'h0000, chk_state_r, err_b_r, err_a_r};
    wire dtsir_word_t rd_mux    =
        pat_hit  ? rd_pat :
        hit_ovr  ? rd_ovr :
        hit_mask ? mask_r :
        hit_id0  ? die_identifier_word[15:0] :
        hit_id1  ? die_identifier_word[31:16] :
        hit_id2  ? die_identifier_word[47:32] :
        hit_id3  ? die_identifier_word[63:48] :
        hit_ctrl ? rd_ctrl :
        hit_stat ? rd_stat :
        16'h0000;

    // Reset values of the pattern words
    function automatic dtsir_code_t pat_reset(input logic [2:0] idx);
        case (idx)
            3'h0:    pat_reset = `DTSIR_RST_WORD0;
            3'h1:    pat_reset = `DTSIR_RST_WORD1;
            3'h2:    pat_reset = `DTSIR_RST_WORD2;
            3'h3:    pat_reset = `DTSIR_RST_WORD3;
            3'h4:    pat_reset = `DTSIR_RST_WORD4;
            3'h5:    pat_reset = `DTSIR_RST_WORD5;
            3'h6:    pat_reset = `DTSIR_RST_WORD6;
            3'h7:    pat_reset = `DTSIR_RST_WORD7;
            default: pat_reset = 14'h0000;
        endcase
    endfunction

    // Pattern words, upper two bits dropped on write
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_pat
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    pat_r[gi] <= pat_reset(3'(gi));
                end else if (wr_pat && pat_idx == 3'(gi)) begin
                    pat_r[gi] <= reg_wdata[13:0];
                end
            end
        end
    endgenerate

    // Override, sleep mask and checker control
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_en_r   <= 1'b0;
            ovr_code_r <= `DTSIR_RST_OVR_CODE;
            mask_r     <= `DTSIR_RST_SLEEP_MASK;
            chk_en_r   <= 1'b0;
        end else begin
            if (wr_ovr) begin
                ovr_en_r   <= reg_wdata[`DTSIR_POS_OVR_EN];
                ovr_code_r <= reg_wdata[13:0];
            end
            if (wr_mask) begin
                mask_r <= reg_wdata;
            end
            if (wr_ctrl) begin
                chk_en_r <= reg_wdata[`DTSIR_POS_CHK_EN];
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Converter code select; data path returns one cycle after clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_a_code <= 14'h0000;
            dac_b_code <= 14'h0000;
        end else begin
            dac_a_code <= ovr_en_r ? ovr_code_r : din_a;
            dac_b_code <= ovr_en_r ? ovr_code_r : din_b;
        end
    end

    // Sleep pin comes from outside, so it is synchronised first
    dtsir_sync2 #(
        .WIDTH    (1)
    ) u_sleep_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (sleep_pin),
        .sync_out (sleep_sync)
    );

    // Bit order: conv A, conv B, fuse, temp, clock, data, sync, align
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            block_sleep <= 8'h00;
        end else begin
            block_sleep <= {8{sleep_sync}} & mask_r[15:`DTSIR_POS_SLEEP_LO];
        end
    end

    // Checker walks the eight words in order, restarting when enabled
    wire dtsir_code_t chk_expect = pat_r[chk_idx_r];
    wire logic        chk_sample = (chk_state_r == DTSIR_CHK_RUN) && din_valid;
    wire logic        miss_a     = chk_sample && (din_a != chk_expect);
    wire logic        miss_b     = chk_sample && (din_b != chk_expect);

    always_comb begin
        case (chk_state_r)
            DTSIR_CHK_IDLE: chk_state_nxt = chk_en_r ? DTSIR_CHK_RUN : DTSIR_CHK_IDLE;
            DTSIR_CHK_RUN:  chk_state_nxt = chk_en_r ? DTSIR_CHK_RUN : DTSIR_CHK_IDLE;
            default:        chk_state_nxt = DTSIR_CHK_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_state_r <= DTSIR_CHK_IDLE;
            chk_idx_r   <= 3'h0;
        end else begin
            chk_state_r <= chk_state_nxt;
            if (chk_state_r != DTSIR_CHK_RUN) begin
                chk_idx_r <= 3'h0;
            end else if (din_valid) begin
                chk_idx_r <= chk_idx_r + 3'h1;
            end
        end
    end

    // Sticky flags, write one to clear; a new miss beats the clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_a_r        <= 1'b0;
            err_b_r        <= 1'b0;
            io_check_error <= 1'b0;
        end else begin
            err_a_r <= miss_a ||
                       (err_a_r && !(wr_stat && reg_wdata[`DTSIR_POS_ERR_A]));
            err_b_r <= miss_b ||
                       (err_b_r && !(wr_stat && reg_wdata[`DTSIR_POS_ERR_B]));
            io_check_error <= err_a_r || err_b_r;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_word_six_store;
        reg_wr && reg_addr == `DTSIR_OFS_WORD6 |=> pat_r[6] == $past(reg_wdata[13:0]);
    endproperty
    a_word_six_store: assert property (p_word_six_store)
        else $error("word six not stored");

    property p_word_seven_read;
        reg_wr && reg_addr == `DTSIR_OFS_WORD7 ##1 reg_rd && reg_addr == `DTSIR_OFS_WORD7
            && !reg_wr |=> reg_rdata == {2'b00, $past(reg_wdata[13:0], 2)};
    endproperty
    a_word_seven_read: assert property (p_word_seven_read)
        else $error("word seven readback wrong");

    property p_miss_flags;
        chk_sample && din_a != chk_expect |=> err_a_r ##1 io_check_error;
    endproperty
    a_miss_flags: assert property (p_miss_flags)
        else $error("mismatch not flagged");

    property p_override_drive;
        ovr_en_r |=> dac_a_code == $past(ovr_code_r) && dac_b_code == $past(ovr_code_r);
    endproperty
    a_override_drive: assert property (p_override_drive)
        else $error("override code not driven");

    property p_data_return;
        $fell(ovr_en_r) |-> ##1 dac_a_code == $past(din_a) && dac_b_code == $past(din_b);
    endproperty
    a_data_return: assert property (p_data_return)
        else $error("data path not restored");

    property p_sleep_route;
        sleep_sync && mask_r[15] && mask_r[8] |=> block_sleep[7] && block_sleep[0];
    endproperty
    a_sleep_route: assert property (p_sleep_route)
        else $error("sleep not forwarded");

    property p_sleep_blocked;
        !mask_r[14] |=> !block_sleep[6];
    endproperty
    a_sleep_blocked: assert property (p_sleep_blocked)
        else $error("masked block put to sleep");

    property p_reserved_zero;
        reg_rd && (pat_hit || hit_ovr) |=> reg_rdata[14] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit reads one");

    property p_id_low_read;
        reg_rd && hit_id0 |=> reg_rdata == $past(die_identifier_word[15:0]);
    endproperty
    a_id_low_read: assert property (p_id_low_read)
        else $error("identifier low slice wrong");

    property p_id_write_ignored;
        reg_wr && (hit_id0 || hit_id1 || hit_id2 || hit_id3) |=>
            $stable(mask_r) && $stable(ovr_code_r) && $stable(ovr_en_r) && $stable(chk_en_r);
    endproperty
    a_id_write_ignored: assert property (p_id_write_ignored)
        else $error("identifier write disturbed state");

    property p_rdata_one_cycle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_one_cycle: assert property (p_rdata_one_cycle)
        else $error("read data held too long");

    property p_word_one_store;
        reg_wr && reg_addr == `DTSIR_OFS_WORD1 |=> pat_r[1] == $past(reg_wdata[13:0]);
    endproperty
    a_word_one_store: assert property (p_word_one_store)
        else $error("word one not stored");

    property p_mask_store;
        reg_wr && hit_mask |=> mask_r == $past(reg_wdata);
    endproperty
    a_mask_store: assert property (p_mask_store)
        else $error("sleep mask not stored");

    property p_align_blocked;
        !mask_r[8] |=> !block_sleep[0];
    endproperty
    a_align_blocked: assert property (p_align_blocked)
        else $error("masked alignment receiver put to sleep");

    property p_id_lmid_read;
        reg_rd && hit_id1 |=> reg_rdata == $past(die_identifier_word[31:16]);
    endproperty
    a_id_lmid_read: assert property (p_id_lmid_read)
        else $error("identifier lower middle slice wrong");

    property p_id_umid_read;
        reg_rd && hit_id2 |=> reg_rdata == $past(die_identifier_word[47:32]);
    endproperty
    a_id_umid_read: assert property (p_id_umid_read)
        else $error("identifier upper middle slice wrong");

    property p_id_high_read;
        reg_rd && hit_id3 |=> reg_rdata == $past(die_identifier_word[63:48]);
    endproperty
    a_id_high_read: assert property (p_id_high_read)
        else $error("identifier high slice wrong");

    // A clear in the same cycle must not swallow a fresh miss
    property p_miss_beats_clear;
        miss_b |=> err_b_r;
    endproperty
    a_miss_beats_clear: assert property (p_miss_beats_clear)
        else $error("new mismatch lost to clear");

    c_override_on:  cover property (ovr_en_r ##1 !ovr_en_r);
    c_sleep_all:    cover property (sleep_sync ##1 block_sleep == 8'hFF);
    c_check_miss:   cover property (chk_sample ##1 err_b_r);
    c_id_high_read: cover property (reg_rd && hit_id3);
endmodule
`default_nettype wire

/* hw/dtsir_sync2.sv */
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module dtsir_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* test/test_dtsir_regs.sv */
// Self-checking bench for the test, sleep and identifier register slice
`timescale 1ns/1ps
`default_nettype none
`include "dtsir_defs.svh"
module test_dtsir_regs;
    import dtsir_pkg::*;
    localparam dtsir_word_t RST_VAL [10] = '{16'h0000, 16'h36B6, 16'h2AEA, 16'h0545, 16'h0585,
        16'h0949, 16'h1515, 16'h3ABA, 16'h0000, 16'hFFFF};
    logic         ref_clk;
    logic         rst_n;
    dtsir_addr_t  reg_addr;
    dtsir_word_t  reg_wdata;
    dtsir_word_t  reg_rdata;
    logic         reg_wr;
    logic         reg_rd;
    dtsir_code_t  din_a;
    dtsir_code_t  din_b;
    logic         din_valid;
    dtsir_code_t  dac_a_code;
    dtsir_code_t  dac_b_code;
    logic         sleep_pin;
    dtsir_sleep_t block_sleep;
    dtsir_id_t    die_identifier_word;
    logic         io_check_error;
    int           error_cnt;
    int           compares;
    int           i;
    logic [31:0]  seed;
    logic [31:0]  r;
    dtsir_word_t  m [8'h0C:8'h15];
    dtsir_word_t  d;
    dtsir_word_t  v;
    logic         m_ovr;
    dtsir_code_t  m_code;
    dtsir_code_t  e_a;
    dtsir_code_t  e_b;

    dtsir_regs DUT (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .din_a               (din_a),
        .din_b               (din_b),
        .din_valid           (din_valid),
        .dac_a_code          (dac_a_code),
        .dac_b_code          (dac_b_code),
        .sleep_pin           (sleep_pin),
        .block_sleep         (block_sleep),
        .die_identifier_word (die_identifier_word),
        .io_check_error      (io_check_error)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
        end
    endtask

    task results;
        $display("compares %0d, error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task wr(input dtsir_addr_t a, input dtsir_word_t w);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a >= 8'h0C && a <= 8'h15) begin
            m[a] = w;
        end
    endtask

    task rd(input dtsir_addr_t a, output dtsir_word_t q);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    // Reserved bits read back as zero, identifier is live
    function automatic dtsir_word_t expv(input dtsir_addr_t a);
        if (a >= 8'h0C && a <= 8'h13) return m[a] & 16'h3FFF;
        if (a == `DTSIR_OFS_OVERRIDE) return m[a] & 16'hBFFF;
        if (a == `DTSIR_OFS_SLEEP_MASK) return m[a];
        if (a >= `DTSIR_OFS_ID_LOW && a <= `DTSIR_OFS_ID_HIGH) begin
            return die_identifier_word[(a - 8'h16) * 16 +: 16];
        end
        return 16'h0000;
    endfunction

    task sweep;
        int k;
        for (k = 8'h0C; k <= 8'h1A; k++) begin
            rd(8'(k), v);
            chk($sformatf("reg %0h", k), 64'(expv(8'(k))), 64'(v));
        end
        rd(8'hFF, v);
        chk("reg ff", 64'h0, 64'(v));
    endtask

    task rnd_din(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            r = xs();
            din_a <= r[13:0];
            din_b <= r[27:14];
        end
    endtask

    // Converter path model: one cycle behind the override register
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            m_ovr  = 1'b0;
            m_code = 14'h0000;
        end else begin
            e_a = m_ovr ? m_code : din_a;
            e_b = m_ovr ? m_code : din_b;
            if (reg_wr && reg_addr == `DTSIR_OFS_OVERRIDE) begin
                m_ovr  = reg_wdata[15];
                m_code = reg_wdata[13:0];
            end
            #1;
            chk("dac_a_code", 64'(e_a), 64'(dac_a_code));
            chk("dac_b_code", 64'(e_b), 64'(dac_b_code));
        end
    end

    initial begin
        #100000;
        error_cnt++;
        results;
    end

    initial begin
        {rst_n, reg_wr, reg_rd, din_valid, sleep_pin} = 5'h00;
        {reg_addr, reg_wdata, din_a, din_b} = 52'h0;
        error_cnt = 0;
        compares  = 0;
        seed      = 32'h000058A1; // 22689
        die_identifier_word = {xs(), xs()};
        for (i = 0; i < 10; i++) m[8'h0C + i] = RST_VAL[i];
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        sweep;
        for (i = 8'h0C; i <= 8'h15; i++) begin
            d = 16'(xs());
            wr(8'(i), d);
        end
        sweep;
        // Identifier and unmapped writes must leave everything alone
        for (i = 8'h16; i <= 8'h1A; i++) begin
            d = 16'(xs());
            wr(8'(i), d);
        end
        wr(8'h40, 16'hFFFF);
        sweep;
        d = 16'(xs());
        wr(`DTSIR_OFS_OVERRIDE, d | 16'hC000);
        rnd_din(10);
        rd(`DTSIR_OFS_OVERRIDE, v);
        chk("override", 64'(expv(8'h14)), 64'(v));
        wr(`DTSIR_OFS_OVERRIDE, d & 16'h7FFF);
        rnd_din(10);
        // Write then read word seven with no idle cycle between
        d = 16'(xs());
        m[`DTSIR_OFS_WORD7] = d;
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= `DTSIR_OFS_WORD7;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("word seven", 64'(d & 16'h3FFF), 64'(reg_rdata));
        // Walk one mask bit, then a random mask with A and align set
        for (i = 0; i < 9; i++) begin
            d = 16'(xs());
            if (i < 8) d = (16'h0100 << i) | (d & 16'h00FF);
            else d = d | 16'h8100;
            wr(`DTSIR_OFS_SLEEP_MASK, d);
            @(posedge ref_clk);
            sleep_pin <= 1'b1;
            repeat (2) @(posedge ref_clk);
            #1 chk("block_sleep early", 64'h0, 64'(block_sleep));
            @(posedge ref_clk);
            #1 chk("block_sleep", 64'(d[15:8]), 64'(block_sleep));
            @(posedge ref_clk);
            sleep_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 chk("block_sleep off", 64'h0, 64'(block_sleep));
        end
        wr(`DTSIR_OFS_CHK_CTRL, 16'h0001);
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            din_valid <= 1'b1;
            din_a     <= m[8'h0C + i][13:0];
            din_b     <= m[8'h0C + i][13:0];
        end
        @(posedge ref_clk);
        din_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("io_check_error", 64'h0, 64'(io_check_error));
        rd(`DTSIR_OFS_CHK_STAT, v);
        chk("status", 64'h4, 64'(v));
        // Wrapped index compares word zero again; only A is wrong
        @(posedge ref_clk);
        din_valid <= 1'b1;
        din_a     <= m[8'h0C][13:0] ^ 14'h0001;
        din_b     <= m[8'h0C][13:0];
        @(posedge ref_clk);
        din_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk("io_check_error", 64'h1, 64'(io_check_error));
        rd(`DTSIR_OFS_CHK_STAT, v);
        chk("status", 64'h5, 64'(v));
        wr(`DTSIR_OFS_CHK_STAT, 16'h0003);
        rd(`DTSIR_OFS_CHK_STAT, v);
        chk("status", 64'h4, 64'(v));
        // Miss on B in the same cycle as a clear: the miss wins
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= `DTSIR_OFS_CHK_STAT;
        reg_wdata <= 16'h0003;
        din_valid <= 1'b1;
        din_a     <= m[8'h0D][13:0];
        din_b     <= m[8'h0D][13:0] ^ 14'h0001;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        din_valid <= 1'b0;
        rd(`DTSIR_OFS_CHK_STAT, v);
        chk("status", 64'h6, 64'(v));
        chk("io_check_error", 64'h1, 64'(io_check_error));
        wr(`DTSIR_OFS_CHK_CTRL, 16'h0000);
        results;
    end
endmodule
`default_nettype wire
